// >>> src/bru_pkg.sv
/*
 * Shared constants and types of the branch instruction unit: opcode
 * encodings, operand field positions, cycle costs and the carriers that
 * travel between the unit and its neighbours.
 * Assumes nothing of its surroundings beyond a SystemVerilog compiler.
 */
package bru_pkg;

	// Opcode encodings of the handled branch forms.
	localparam logic [3:0] BRU_OP_SHORT_HI   = 4'h7;
	localparam logic [3:0] BRU_CC_LAST       = 4'hd;
	localparam logic [7:0] BRU_OP_FAR_DIRECT = 8'hea;
	localparam logic [7:0] BRU_OP_GROUP_FF   = 8'hff;

	// Condition codes held in the low opcode nibble of a short branch.
	localparam logic [3:0] BRU_CC_WRAP       = 4'h0;
	localparam logic [3:0] BRU_CC_NO_WRAP    = 4'h1;
	localparam logic [3:0] BRU_CC_CARRY      = 4'h2;
	localparam logic [3:0] BRU_CC_NO_CARRY   = 4'h3;
	localparam logic [3:0] BRU_CC_EQUAL      = 4'h4;
	localparam logic [3:0] BRU_CC_NOT_EQUAL  = 4'h5;
	localparam logic [3:0] BRU_CC_NOT_HIGHER = 4'h6;
	localparam logic [3:0] BRU_CC_HIGHER     = 4'h7;
	localparam logic [3:0] BRU_CC_NEGATIVE   = 4'h8;
	localparam logic [3:0] BRU_CC_POSITIVE   = 4'h9;
	localparam logic [3:0] BRU_CC_PAR_EVEN   = 4'ha;
	localparam logic [3:0] BRU_CC_PAR_ODD    = 4'hb;
	localparam logic [3:0] BRU_CC_LESS       = 4'hc;
	localparam logic [3:0] BRU_CC_GE_EQ      = 4'hd;

	// Operand byte field positions and values.
	localparam int         BRU_MOD_HI        = 7;
	localparam int         BRU_MOD_LO        = 6;
	localparam int         BRU_REG_HI        = 5;
	localparam int         BRU_REG_LO        = 3;
	localparam int         BRU_SIGN_BIT      = 7;
	localparam logic [1:0] BRU_MOD_REGISTER  = 2'h3;
	localparam logic [2:0] BRU_REG_NEAR_MEM  = 3'h4;
	localparam logic [2:0] BRU_REG_FAR_MEM   = 3'h5;

	// Costs in processor clock cycles.
	localparam int         BRU_COST_W        = 6;
	localparam logic [5:0] BRU_CYC_NEAR_MEM  = 6'h18;
	localparam logic [5:0] BRU_CYC_NEAR_FAST = 6'h14;
	localparam logic [5:0] BRU_CYC_FAR_DIR   = 6'h0f;
	localparam logic [5:0] BRU_CYC_FAR_MEM   = 6'h23;
	localparam logic [5:0] BRU_CYC_FAR_FAST  = 6'h1b;
	localparam logic [5:0] BRU_CYC_TAKEN     = 6'h0e;
	localparam logic [5:0] BRU_CYC_FALL      = 6'h04;
	localparam logic [5:0] BRU_CYC_NONE      = 6'h00;

	// Bus transfers, instruction lengths and the pointer word step.
	localparam logic [1:0] BRU_XFER_NONE     = 2'h0;
	localparam logic [1:0] BRU_XFER_ONE      = 2'h1;
	localparam logic [1:0] BRU_XFER_TWO      = 2'h2;
	localparam logic [2:0] BRU_LEN_SHORT     = 3'h2;
	localparam logic [2:0] BRU_LEN_FAR_DIR   = 3'h5;
	localparam logic [15:0] BRU_WORD_STEP    = 16'h0002;

	// Flag bits read from the processor flag register.
	typedef struct packed {
		logic signed_wrap_bit;
		logic carry_flag;
		logic equal_result_bit;
		logic negative_indicator;
		logic even_ones_bit;
	} bru_flags_s;

	// Instruction bytes one to five as fetched.
	typedef struct packed {
		logic [7:0] opcode;
		logic [7:0] byte2;
		logic [7:0] byte3;
		logic [7:0] byte4;
		logic [7:0] byte5;
	} bru_instr_s;

	// Outcome of one branch.
	typedef struct packed {
		logic [15:0] pc;
		logic [15:0] cs;
		logic [5:0]  cost;
		logic [1:0]  xfers;
		logic [2:0]  length;
		logic        taken;
	} bru_result_s;

	typedef enum logic [1:0] {
		BRU_IDLE,
		BRU_READ_LO,
		BRU_READ_HI,
		BRU_SETTLE
	} bru_state_e;

endpackage

// >>> src/bru_cond_eval.sv
/*
 * Condition evaluator of the short conditional branches: maps the low
 * opcode nibble and the flag bits to a take decision.
 * Assumes flags stable in the cycle the decision is used; purely combinational.
 */
`timescale 1ns/1ps
module bru_cond_eval
	import bru_pkg::*;
(
	// Condition select
	input  wire logic [3:0]         code,
	// Flag register bits
	input  wire bru_pkg::bru_flags_s flags,
	// Decision
	output logic                    take
);

	// Each pair of codes is a condition and its inverse; flags are only read.
	always_comb
	begin
		take = 1'b0;
		case (code)
			BRU_CC_WRAP:       take = flags.signed_wrap_bit;
			BRU_CC_NO_WRAP:    take = ~flags.signed_wrap_bit;
			BRU_CC_CARRY:      take = flags.carry_flag;
			BRU_CC_NO_CARRY:   take = ~flags.carry_flag;
			BRU_CC_EQUAL:      take = flags.equal_result_bit;
			BRU_CC_NOT_EQUAL:  take = ~flags.equal_result_bit;
			BRU_CC_NOT_HIGHER: take = flags.carry_flag | flags.equal_result_bit;
			BRU_CC_HIGHER:     take = ~(flags.carry_flag | flags.equal_result_bit);
			BRU_CC_NEGATIVE:   take = flags.negative_indicator;
			BRU_CC_POSITIVE:   take = ~flags.negative_indicator;
			BRU_CC_PAR_EVEN:   take = flags.even_ones_bit;
			BRU_CC_PAR_ODD:    take = ~flags.even_ones_bit;
			BRU_CC_LESS:       take = flags.negative_indicator ^ flags.signed_wrap_bit;
			BRU_CC_GE_EQ:      take = ~(flags.negative_indicator ^ flags.signed_wrap_bit);
			default:           take = 1'b0;
		endcase
	end

endmodule

// >>> src/bru_cycle_timer.sv
/*
 * Cycle cost timer: a divider makes the processor cycle enable from the
 * system clock, and a down counter spends the loaded number of those cycles.
 * Assumes load is a one-cycle pulse from logic on the same clock.
 */
`timescale 1ns/1ps
module bru_cycle_timer #(
	parameter int CNT_W = 6,
	parameter int DIV   = 1
)(
	// Clock and reset
	input  wire logic             clock,
	input  wire logic             rst,
	// Load of a new cost
	input  wire logic             load,
	input  wire logic [CNT_W-1:0] load_value,
	// Status
	output logic                  expired
);

	localparam int DIV_W = (DIV > 1) ? $clog2(DIV) : 1;
	localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(DIV - 1);

	logic [DIV_W-1:0] div_q;
	logic [DIV_W-1:0] div_d;
	logic [CNT_W-1:0] cnt_q;
	logic [CNT_W-1:0] cnt_d;
	logic             tick;

	// The divider restarts on load so every cost starts on a whole cycle.
	always_comb
	begin
		tick  = (div_q == DIV_LAST);
		div_d = tick ? '0 : div_q + 1'b1;
		cnt_d = cnt_q;
		if (load)
		begin
			div_d = '0;
			cnt_d = load_value;
		end
		else if (tick && (cnt_q != '0))
		begin
			cnt_d = cnt_q - 1'b1;
		end
	end

	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			div_q <= '0;
			cnt_q <= '0;
		end
		else
		begin
			div_q <= div_d;
			cnt_q <= cnt_d;
		end
	end

	assign expired = (cnt_q == '0);

endmodule

// >>> src/bru_branch_unit.sv
/*
 * Branch instruction unit: executes the memory, far and short conditional
 * branch forms, forms the new program counter and code segment, fetches
 * pointer words through the bus unit and spends each form's cycle cost.
 * Assumes the fetch path presents all instruction bytes, the effective
 * operand address and the program counter already past the instruction,
 * all on this clock; the bus unit answers each word with a one-cycle ack.
 */
// Function
// - Near memory jump loads PC from one word; 24 cycles, 20 wide-even.
// - Far direct jump takes PC from bytes two-three, segment from four-five; 15.
// - Far memory jump loads PC low word, segment high word; 35, 27 wide-even.
// - Short branch target is PC plus sign-extended offset byte; two bytes long.
// - Untaken short branch leaves PC at next instruction; no flags change.
// - Wrap branch taken when wrap bit is one; 14 taken, 4 not.
// - No-wrap branch taken when wrap bit is zero; 14 taken, 4 not.
// - Carry branch, opcode 72h, taken on carry one; 14 either way.
// - No-carry branch, opcode 73h, taken on carry zero; 14 either way.
// - Equal branch, opcode 74h, taken on equal bit one; 14 or 4.
// - Not-equal branch, opcode 75h, taken on equal bit zero; 14 or 4.
// - Not-higher branch taken when carry OR equal is one; 14 or 4.
// - Higher branch taken when carry OR equal is zero; 14 or 4.
// - Negative branch, opcode 78h, taken on negative one; 14 or 4.
// - Positive branch, opcode 79h, taken on negative zero; 14 or 4.
// - Parity-even branch taken when even-ones bit is one; 14 or 4.
// - Parity-odd branch taken when even-ones bit is zero; 14 or 4.
// - Signed-less branch taken when negative XOR wrap is one; 14 or 4.
// - Signed greater-equal taken when negative XOR wrap is zero, else falls through.
// - Signed greater-equal costs 14 taken, 4 not, with no bus transfer.

`timescale 1ns/1ps
module bru_branch_unit
	import bru_pkg::*;
#(
	parameter int CPU_DIV = 1
)(
	// Clock and reset
	input  wire logic                 clock,
	input  wire logic                 rst,
	// Branch request from the fetch path
	input  wire logic                 start,
	input  wire bru_pkg::bru_instr_s  instr,
	input  wire logic [15:0]          pc_next,
	input  wire logic [15:0]          cs_cur,
	input  wire logic [15:0]          operand_addr,
	input  wire logic                 wide_bus,
	// Flag register
	input  wire bru_pkg::bru_flags_s  flags,
	// Bus unit word reads
	output logic                      mem_req,
	output logic [15:0]               mem_addr,
	input  wire logic [15:0]          mem_rdata,
	input  wire logic                 mem_ack,
	// Outcome
	output logic                      busy,
	output logic                      done,
	output logic                      illegal,
	output bru_pkg::bru_result_s      result
);

	import bru_pkg::*;

	// Decoded view of the presented instruction.
	logic [1:0]        mod_f;
	logic [2:0]        reg_f;
	logic              is_short;
	logic              is_far_dir;
	logic              is_near_mem;
	logic              is_far_mem;
	logic              even_fast;
	logic              cond_take;
	logic [15:0]       short_target;

	// State of the sequence and its registered outputs.
	bru_state_e        state_q;
	bru_state_e        state_d;
	logic              far_q;
	logic              far_d;
	logic              busy_q;
	logic              busy_d;
	logic              done_q;
	logic              done_d;
	logic              illegal_q;
	logic              illegal_d;
	logic              mem_req_q;
	logic              mem_req_d;
	logic [15:0]       mem_addr_q;
	logic [15:0]       mem_addr_d;
	bru_result_s       result_q;
	bru_result_s       result_d;

	// Timer control.
	logic              timer_load;
	logic [5:0]        timer_value;
	logic              timer_expired;

	// Field extraction and form decode; the register forms are not handled.
	assign mod_f       = instr.byte2[BRU_MOD_HI:BRU_MOD_LO];
	assign reg_f       = instr.byte2[BRU_REG_HI:BRU_REG_LO];
	assign is_short    = (instr.opcode[7:4] == BRU_OP_SHORT_HI)
	                   && (instr.opcode[3:0] <= BRU_CC_LAST);
	assign is_far_dir  = (instr.opcode == BRU_OP_FAR_DIRECT);
	assign is_near_mem = (instr.opcode == BRU_OP_GROUP_FF)
	                   && (mod_f != BRU_MOD_REGISTER) && (reg_f == BRU_REG_NEAR_MEM);
	assign is_far_mem  = (instr.opcode == BRU_OP_GROUP_FF)
	                   && (mod_f != BRU_MOD_REGISTER) && (reg_f == BRU_REG_FAR_MEM);

	// The faster pointer costs apply only to a wide bus at an even address.
	assign even_fast   = wide_bus && ~operand_addr[0];

	// Sign extension keeps the target within the segment, wrapping at 64K.
	assign short_target = pc_next
	                    + {{8{instr.byte2[BRU_SIGN_BIT]}}, instr.byte2};

	// Condition decision on the flags sampled in the start cycle.
	bru_cond_eval u_cond (
		.code  (instr.opcode[3:0]),
		.flags (flags),
		.take  (cond_take)
	);

	// Cost spent in processor cycles derived from the system clock.
	bru_cycle_timer #(
		.CNT_W (BRU_COST_W),
		.DIV   (CPU_DIV)
	) u_timer (
		.clock      (clock),
		.rst        (rst),
		.load       (timer_load),
		.load_value (timer_value),
		.expired    (timer_expired)
	);

	// Cost of the presented form, chosen before the sequence starts.
	always_comb
	begin
		timer_value = BRU_CYC_NONE;
		if (is_short)
		begin
			if (instr.opcode[3:0] == BRU_CC_CARRY || instr.opcode[3:0] == BRU_CC_NO_CARRY)
				timer_value = BRU_CYC_TAKEN;
			else
				timer_value = cond_take ? BRU_CYC_TAKEN : BRU_CYC_FALL;
		end
		else if (is_far_dir)
			timer_value = BRU_CYC_FAR_DIR;
		else if (is_near_mem)
			timer_value = even_fast ? BRU_CYC_NEAR_FAST : BRU_CYC_NEAR_MEM;
		else if (is_far_mem)
			timer_value = even_fast ? BRU_CYC_FAR_FAST : BRU_CYC_FAR_MEM;
	end

	// Sequence: accept, fetch pointer words, then wait out the cost.
	// A request during busy is ignored, since the fetch path stalls on busy.
	always_comb
	begin
		state_d    = state_q;
		far_d      = far_q;
		busy_d     = busy_q;
		done_d     = 1'b0;
		illegal_d  = 1'b0;
		mem_req_d  = mem_req_q;
		mem_addr_d = mem_addr_q;
		result_d   = result_q;
		timer_load = 1'b0;
		case (state_q)
			BRU_IDLE:
			begin
				if (start)
				begin
					result_d.pc     = pc_next;
					result_d.cs     = cs_cur;
					result_d.cost   = timer_value;
					result_d.xfers  = BRU_XFER_NONE;
					result_d.length = BRU_LEN_SHORT;
					result_d.taken  = 1'b0;
					if (is_short)
					begin
						// Untaken keeps the next-instruction PC; flags are never written.
						result_d.pc    = cond_take ? short_target : pc_next;
						result_d.taken = cond_take;
						timer_load     = 1'b1;
						busy_d         = 1'b1;
						state_d        = BRU_SETTLE;
					end
					else if (is_far_dir)
					begin
						result_d.pc     = {instr.byte3, instr.byte2};
						result_d.cs     = {instr.byte5, instr.byte4};
						result_d.length = BRU_LEN_FAR_DIR;
						result_d.taken  = 1'b1;
						timer_load      = 1'b1;
						busy_d          = 1'b1;
						state_d         = BRU_SETTLE;
					end
					else if (is_near_mem || is_far_mem)
					begin
						result_d.xfers = is_far_mem ? BRU_XFER_TWO : BRU_XFER_ONE;
						result_d.taken = 1'b1;
						far_d          = is_far_mem;
						mem_req_d      = 1'b1;
						mem_addr_d     = operand_addr;
						timer_load     = 1'b1;
						busy_d         = 1'b1;
						state_d        = BRU_READ_LO;
					end
					else
					begin
						// Unhandled forms answer at once and leave PC and segment alone.
						result_d.cost = BRU_CYC_NONE;
						done_d        = 1'b1;
						illegal_d     = 1'b1;
					end
				end
			end
			BRU_READ_LO:
			begin
				if (mem_ack)
				begin
					result_d.pc = mem_rdata;
					if (far_q)
					begin
						mem_addr_d = mem_addr_q + BRU_WORD_STEP;
						state_d    = BRU_READ_HI;
					end
					else
					begin
						mem_req_d = 1'b0;
						state_d   = BRU_SETTLE;
					end
				end
			end
			BRU_READ_HI:
			begin
				if (mem_ack)
				begin
					result_d.cs = mem_rdata;
					mem_req_d   = 1'b0;
					state_d     = BRU_SETTLE;
				end
			end
			BRU_SETTLE:
			begin
				// A slow bus can outlast the cost; then the end follows the last word.
				if (timer_expired)
				begin
					done_d  = 1'b1;
					busy_d  = 1'b0;
					state_d = BRU_IDLE;
				end
			end
			default:
			begin
				state_d   = BRU_IDLE;
				busy_d    = 1'b0;
				mem_req_d = 1'b0;
			end
		endcase
	end

	// Registers of the sequence.
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			state_q    <= BRU_IDLE;
			far_q      <= 1'b0;
			busy_q     <= 1'b0;
			done_q     <= 1'b0;
			illegal_q  <= 1'b0;
			mem_req_q  <= 1'b0;
			mem_addr_q <= 16'h0000;
			result_q   <= '0;
		end
		else
		begin
			state_q    <= state_d;
			far_q      <= far_d;
			busy_q     <= busy_d;
			done_q     <= done_d;
			illegal_q  <= illegal_d;
			mem_req_q  <= mem_req_d;
			mem_addr_q <= mem_addr_d;
			result_q   <= result_d;
		end
	end

	// Every output is a register.
	assign busy     = busy_q;
	assign done     = done_q;
	assign illegal  = illegal_q;
	assign mem_req  = mem_req_q;
	assign mem_addr = mem_addr_q;
	assign result   = result_q;

endmodule

// >>> tb/bru_mem_model.sv
/*
 * Bus unit model: answers each word read after a set wait, data taken from the address.
 * Assumes the clock and reset of the unit under test.
 */
`timescale 1ns/1ps
module bru_mem_model #(
	parameter logic [15:0] KEY = 16'hc3a5
)(
	// Clock and reset
	input  wire logic        clock,
	input  wire logic        rst,
	// Wait cycles before each answer
	input  wire logic [3:0]  lat,
	// Word read port
	input  wire logic        mem_req,
	input  wire logic [15:0] mem_addr,
	output logic [15:0]      mem_rdata,
	output logic             mem_ack
);
	logic [3:0] cnt_q;

	// Data is inverted outside the ack cycle, so a late sample never matches.
	assign mem_rdata = mem_ack ? (mem_addr ^ KEY) : ~(mem_addr ^ KEY);

	// Count wait cycles while a request stands, then pulse ack once per word.
	always_ff @(posedge clock)
	begin
		if (rst || !mem_req || mem_ack)
		begin
			cnt_q   <= 4'h0;
			mem_ack <= 1'b0;
		end
		else
		begin
			mem_ack <= (cnt_q == lat);
			cnt_q   <= cnt_q + 4'h1;
		end
	end
endmodule

// >>> tb/bru_branch_unit_asserts.sv
/*
 * Checker of the branch unit: targets, costs and pointer word handling.
 * Assumes CPU_DIV of 1, so the done delays below are in system cycles.
 */
`timescale 1ns/1ps
module bru_branch_unit_asserts
	import bru_pkg::*;
#(
	parameter int CPU_DIV = 1
)(
	// Clock and reset
	input wire logic                clock,
	input wire logic                rst,
	// Request
	input wire logic                start,
	input wire bru_pkg::bru_instr_s instr,
	input wire logic [15:0]         pc_next,
	input wire logic [15:0]         cs_cur,
	input wire logic [15:0]         operand_addr,
	input wire logic                wide_bus,
	input wire bru_pkg::bru_flags_s flags,
	// Bus unit
	input wire logic                mem_req,
	input wire logic [15:0]         mem_addr,
	input wire logic [15:0]         mem_rdata,
	input wire logic                mem_ack,
	// Outcome
	input wire logic                busy,
	input wire logic                done,
	input wire logic                illegal,
	input wire bru_pkg::bru_result_s result
);
	logic        acc, shrt, c, hit, long_c, near_m, far_m;
	logic [5:0]  near_cost, far_cost;
	logic [15:0] exp_pc, far_pc, far_cs, ea_d, ea_q;

	// Decode of the request seen at the accept edge, and the address kept.
	always_comb
	begin
		case (instr.opcode[3:1])
			3'h0: c = flags.signed_wrap_bit;
			3'h1: c = flags.carry_flag;
			3'h2: c = flags.equal_result_bit;
			3'h3: c = flags.carry_flag | flags.equal_result_bit;
			3'h4: c = flags.negative_indicator;
			3'h5: c = flags.even_ones_bit;
			default: c = flags.negative_indicator ^ flags.signed_wrap_bit;
		endcase
		acc = start && !busy;
		shrt = instr.opcode[7:4] == BRU_OP_SHORT_HI && instr.opcode[3:0] <= BRU_CC_LAST;
		hit = c ^ instr.opcode[0];
		long_c = hit || instr.opcode[3:1] == 3'h1;
		exp_pc = hit ? pc_next + {{8{instr.byte2[7]}}, instr.byte2} : pc_next;
		far_pc = {instr.byte3, instr.byte2};
		far_cs = {instr.byte5, instr.byte4};
		near_m = instr.opcode == BRU_OP_GROUP_FF && instr.byte2[7:6] != BRU_MOD_REGISTER
			&& instr.byte2[5:3] == BRU_REG_NEAR_MEM;
		far_m = instr.opcode == BRU_OP_GROUP_FF && instr.byte2[7:6] != BRU_MOD_REGISTER
			&& instr.byte2[5:3] == BRU_REG_FAR_MEM;
		near_cost = (wide_bus && !operand_addr[0]) ? BRU_CYC_NEAR_FAST : BRU_CYC_NEAR_MEM;
		far_cost = (wide_bus && !operand_addr[0]) ? BRU_CYC_FAR_FAST : BRU_CYC_FAR_MEM;
		ea_d = acc ? operand_addr : ea_q;
	end

	// Operand address held for the word checks below.
	always_ff @(posedge clock)
	begin
		ea_q <= rst ? 16'h0 : ea_d;
	end

	default clocking @(posedge clock); endclocking
	default disable iff (rst);

	AST_SHORT_PC: assert property (acc && shrt |=> result.pc == $past(exp_pc))
		else $error("short branch target wrong");
	AST_SHORT_LONG: assert property (acc && shrt && long_c
		|-> ##1 result.cost == BRU_CYC_TAKEN ##15 done) else $error("long short cost wrong");
	AST_SHORT_FALL: assert property (acc && shrt && !long_c
		|-> ##1 result.cost == BRU_CYC_FALL ##5 done) else $error("fall through cost wrong");
	AST_SHORT_NO_BUS: assert property (acc && shrt
		|=> (!mem_req && result.xfers == BRU_XFER_NONE && result.length == BRU_LEN_SHORT)[*4])
		else $error("short branch used the bus");
	AST_FAR_DIRECT: assert property (acc && instr.opcode == BRU_OP_FAR_DIRECT
		|-> ##1 result.pc == $past(far_pc) && result.cs == $past(far_cs)
		&& result.cost == BRU_CYC_FAR_DIR ##16 done) else $error("far direct wrong");
	AST_NEAR_REQ: assert property (acc && near_m |=> mem_req
		&& mem_addr == $past(operand_addr) && result.cs == $past(cs_cur)
		&& result.cost == $past(near_cost)) else $error("near memory start wrong");
	AST_FAR_REQ: assert property (acc && far_m |=> mem_req
		&& mem_addr == $past(operand_addr) && result.xfers == BRU_XFER_TWO
		&& result.cost == $past(far_cost)) else $error("far memory start wrong");
	AST_WORD_LOW: assert property (mem_req && mem_ack && mem_addr == ea_q
		|=> result.pc == $past(mem_rdata)) else $error("pointer low word lost");
	AST_WORD_HIGH: assert property (mem_req && mem_ack && mem_addr == ea_q + BRU_WORD_STEP
		|=> result.cs == $past(mem_rdata) && !mem_req) else $error("pointer high word lost");
	AST_REQ_HOLD: assert property (mem_req && !mem_ack
		|=> mem_req && $stable(mem_addr)) else $error("word request dropped early");
endmodule

bind bru_branch_unit bru_branch_unit_asserts #(
	.CPU_DIV(CPU_DIV)
) i_asserts (
	.clock(clock), .rst(rst), .start(start), .instr(instr), .pc_next(pc_next),
	.cs_cur(cs_cur), .operand_addr(operand_addr), .wide_bus(wide_bus), .flags(flags),
	.mem_req(mem_req), .mem_addr(mem_addr), .mem_rdata(mem_rdata), .mem_ack(mem_ack),
	.busy(busy), .done(done), .illegal(illegal), .result(result)
);

// >>> tb/testbench.sv
/*
 * Self-checking bench of the branch unit: short, far, memory and refused forms.
 * Assumes the unit, its checker and the bus model are compiled first.
 */
`timescale 1ns/1ps
module testbench;
	import bru_pkg::*;
	localparam logic [15:0] KEY = 16'hc3a5;
	localparam logic [15:0] PCB = 16'hffc0;
	localparam logic [15:0] CSB = 16'h2b00;
	logic        clock, rst, start, wide_bus, mem_req, mem_ack, busy, done, illegal;
	logic [3:0]  lat;
	logic [15:0] operand_addr, mem_addr, mem_rdata;
	bru_instr_s  instr;
	bru_flags_s  flags;
	bru_result_s result;
	int          n_mismatch, checks, cyc;

	bru_branch_unit #(
		.CPU_DIV(1)
	) i_dut (
		.clock(clock), .rst(rst), .start(start), .instr(instr), .pc_next(PCB), .cs_cur(CSB),
		.operand_addr(operand_addr), .wide_bus(wide_bus), .flags(flags), .mem_req(mem_req),
		.mem_addr(mem_addr), .mem_rdata(mem_rdata), .mem_ack(mem_ack), .busy(busy),
		.done(done), .illegal(illegal), .result(result)
	);

	bru_mem_model #(
		.KEY(KEY)
	) i_mem (
		.clock(clock), .rst(rst), .lat(lat), .mem_req(mem_req), .mem_addr(mem_addr),
		.mem_rdata(mem_rdata), .mem_ack(mem_ack)
	);

	// Free running clock of 8 ns.
	initial clock = 1'b0;
	always #4 clock = ~clock;

	// A hung run is cut short well after the expected length of about 6000 cycles.
	always @(posedge clock)
	begin
		cyc <= cyc + 1;
		if (cyc == 40000)
		begin
			n_mismatch++;
			close_out();
		end
	end

	task close_out;
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Expected decision of each condition code, written out case by case.
	function automatic logic exp_take(input logic [3:0] cc, input bru_flags_s f);
		case (cc)
			4'h0: return f.signed_wrap_bit;
			4'h1: return !f.signed_wrap_bit;
			4'h2: return f.carry_flag;
			4'h3: return !f.carry_flag;
			4'h4: return f.equal_result_bit;
			4'h5: return !f.equal_result_bit;
			4'h6: return f.carry_flag || f.equal_result_bit;
			4'h7: return !(f.carry_flag || f.equal_result_bit);
			4'h8: return f.negative_indicator;
			4'h9: return !f.negative_indicator;
			4'ha: return f.even_ones_bit;
			4'hb: return !f.even_ones_bit;
			4'hc: return f.negative_indicator != f.signed_wrap_bit;
			default: return f.negative_indicator == f.signed_wrap_bit;
		endcase
	endfunction

	// One request from an edge; n counts edges until done was seen high.
	task run(input bru_instr_s i, input bru_flags_s f, input logic [15:0] ea,
		input logic w, output int n, output logic ill);
		instr <= i;
		flags <= f;
		operand_addr <= ea;
		wide_bus <= w;
		start <= 1'b1;
		@(posedge clock);
		start <= 1'b0;
		n = 0;
		do
		begin
			@(posedge clock);
			n++;
		end
		while (done !== 1'b1 && n < 80);
		ill = illegal;
	endtask

	// Every code under all flag patterns, offsets at both ends of the byte range.
	task t_short;
		int n;
		logic ill, tk, lg;
		bru_instr_s i;
		for (int c = 0; c < 14; c++)
			for (int f = 0; f < 32; f++)
			begin
				i = '{8'h70 | 8'(c), f[0] ? 8'h7f : 8'h80, 8'h00, 8'h00, 8'h00};
				tk = exp_take(4'(c), bru_flags_s'(f[4:0]));
				lg = tk || c == 2 || c == 3;
				run(i, bru_flags_s'(f[4:0]), 16'h0000, 1'b0, n, ill);
				check(result.pc, tk ? 16'(PCB + {{8{i.byte2[7]}}, i.byte2}) : PCB);
				check({result.cs, 5'(result.taken), result.length}, {CSB, 5'(tk), 3'h2});
				check(result.cost, lg ? 6'h0e : 6'h04);
				check(n, lg ? 16 : 6);
			end
	endtask

	// Far direct, then a short branch started in the far branch's done cycle.
	task t_far;
		int n;
		logic ill;
		instr <= '{8'hea, 8'h34, 8'h12, 8'hcd, 8'hab};
		start <= 1'b1;
		@(posedge clock);
		start <= 1'b0;
		repeat (16) @(posedge clock);
		check({result.pc, result.cs}, 32'h1234abcd);
		check({result.cost, result.length}, {6'h0f, 3'h5});
		run('{8'h74, 8'h10, 8'h00, 8'h00, 8'h00}, 5'h04, 16'h0000, 1'b0, n, ill);
		check(result.pc, PCB + 16'h0010);
		check(n, 16);
	endtask

	// Near and far pointer forms on both bus widths and address parities, then a slow bus.
	task t_mem;
		int n;
		logic ill, fast;
		logic [15:0] ea;
		logic [5:0] cost;
		for (int k = 0; k < 8; k++)
		begin
			ea = 16'h4a10 | 16'(k[0]);
			fast = k[1] && !k[0];
			cost = k[2] ? (fast ? 6'h1b : 6'h23) : (fast ? 6'h14 : 6'h18);
			run('{8'hff, k[2] ? 8'h2e : 8'h26, 8'h00, 8'h00, 8'h00}, 5'h00, ea, k[1], n, ill);
			check(result.pc, ea ^ KEY);
			check(result.cs, k[2] ? (ea + 16'h0002) ^ KEY : CSB);
			check({result.cost, result.xfers}, {cost, k[2] ? 2'h2 : 2'h1});
			check(n, cost + 2);
		end
		lat <= 4'he;
		run('{8'hff, 8'hae, 8'h00, 8'h00, 8'h00}, 5'h00, 16'h0800, 1'b1, n, ill);
		check({result.pc, result.cs}, {16'h0800 ^ KEY, 16'h0802 ^ KEY});
		check(n, 34);
		lat <= 4'h2;
	endtask

	// Forms outside the unit's set end at once with the entry state kept.
	task t_illegal;
		int n;
		logic ill;
		logic [7:0] op [6] = '{8'h7e, 8'h7f, 8'h90, 8'hff, 8'hff, 8'hff};
		logic [7:0] b2 [6] = '{8'h00, 8'h00, 8'h00, 8'hc0, 8'h06, 8'he8};
		for (int k = 0; k < 6; k++)
		begin
			run('{op[k], b2[k], 8'h00, 8'h00, 8'h00}, 5'h1f, 16'h0000, 1'b1, n, ill);
			check({n[7:0], 7'(ill), 1'(result.taken)}, 16'h0102);
			check({result.pc, result.cs}, {PCB, CSB});
			check(result.cost, 6'h00);
		end
	endtask

	// Reset for 20 cycles, then the scenarios in turn.
	initial
	begin
		rst = 1'b1;
		start = 1'b0;
		instr = '0;
		flags = '0;
		operand_addr = 16'h0000;
		wide_bus = 1'b0;
		lat = 4'h2;
		repeat (20) @(posedge clock);
		rst <= 1'b0;
		@(posedge clock);
		check({busy, done, illegal, mem_req}, 0);
		check(result[31:0], 0);
		t_short;
		t_far;
		t_mem;
		t_illegal;
		close_out();
	end
endmodule
